/* File: rtl/vtr_front.sv */
/*
 viewport store, primitive selection and drop, bounds and colour stage, register slave.
 assumes an AXI4-Lite master on the same clock and a rasterizer taking outValid/outReady.
*/
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module vtr_front #(
    parameter int NUM_VP = 16,
    parameter logic [15:0] WIN_W = 16'd640,
    parameter logic [15:0] WIN_H = 16'd480,
    parameter bit WINDOW_PRESENT = 1'b1,
    parameter logic [15:0] DISPLAY_DIM = 16'd4096,
    parameter logic [15:0] TARGET_DIM = 16'd8192,
    parameter logic signed [15:0] BOUND_MIN = -16'sd16384,
    parameter logic signed [15:0] BOUND_MAX = 16'sd16383,
    parameter logic [15:0] FB_W = 16'd640,
    parameter logic [15:0] FB_H = 16'd480
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // register bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // primitives in
    input wire logic primValid,
    output logic primReady,
    input wire logic gsActive,
    input wire logic [1:0] primStream,
    input wire logic [7:0] primVpIdx,
    input wire logic signed [15:0] fragX,
    input wire logic signed [15:0] fragY,
    input wire logic [31:0] primColor,
    // fragments out
    output logic outValid,
    input wire logic outReady,
    output logic [16:0] outCenterX,
    output logic [16:0] outCenterY,
    output logic [16:0] outOriginX,
    output logic [16:0] outOriginY,
    output logic [15:0] outScaleW,
    output logic [15:0] outScaleH,
    output logic [31:0] outColor,
    // pixel operations
    output logic opValid,
    output logic [2:0] opCode
);
    localparam logic [15:0] MAX_DIM = (DISPLAY_DIM > TARGET_DIM) ? DISPLAY_DIM : TARGET_DIM;
    localparam logic [15:0] INIT_W = WINDOW_PRESENT ? WIN_W : 16'h0000;
    localparam logic [15:0] INIT_H = WINDOW_PRESENT ? WIN_H : 16'h0000;

    typedef struct packed {
        logic awready;
        logic wready;
        logic awHave;
        logic wHave;
        logic [7:0] awAddr;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] ctrl;
        logic [7:0] first;
        logic [31:0] count;
        logic [31:0] sx;
        logic [31:0] sy;
        logic [31:0] sw;
        logic [31:0] sh;
        logic errSticky;
        logic [7:0] sel;
        logic opValid;
        logic [2:0] opCode;
        logic primReady;
        logic outValid;
        logic [16:0] outCx;
        logic [16:0] outCy;
        logic [16:0] outOx;
        logic [16:0] outOy;
        logic [15:0] outW;
        logic [15:0] outH;
        logic [31:0] outColor;
        vtr_pkg::vtr_vp_t [NUM_VP-1:0] vp;
    } vtr_state_t;

    vtr_state_t st_q;
    vtr_state_t st_d;
    vtr_pkg::vtr_vp_t clampVp;
    logic clampNeg;
    logic [31:0] convColor;
    logic doWrite;
    logic doCmd;
    logic rangeBad;
    logic accept;
    logic pass;
    logic [31:0] rangeEnd;
    vtr_pkg::vtr_vp_t selVp;
    vtr_pkg::vtr_vp_t rdVp;
    logic [16:0] rdOx;
    logic [16:0] rdOy;

    // center in half-pixel units: 2x + w
    function automatic logic [16:0] vpCenter(input logic signed [15:0] c, input logic [15:0] e);
        return 17'({c[15], c, 1'b0}) + 17'(e);
    endfunction

    function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] nw,
            input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    vtr_vp_clamp #(
        .BOUND_MIN(BOUND_MIN),
        .BOUND_MAX(BOUND_MAX),
        .MAX_DIM(MAX_DIM)
    ) u_clamp (
        .inX(st_q.sx),
        .inY(st_q.sy),
        .inW(st_q.sw),
        .inH(st_q.sh),
        .vp(clampVp),
        .negative(clampNeg)
    );

    vtr_color_conv u_conv (
        .colorIn(primColor),
        .clampEn(st_q.ctrl[vtr_pkg::CTRL_CLAMP]),
        .signedFmt(st_q.ctrl[vtr_pkg::CTRL_SIGNED]),
        .indexMode(st_q.ctrl[vtr_pkg::CTRL_INDEX]),
        .colorOut(convColor)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        doWrite = st_q.awHave && st_q.wHave && !st_q.bvalid;
        doCmd = doWrite && st_q.awAddr == vtr_pkg::OFS_CMD;
        rangeEnd = 32'(st_q.first) + st_q.count;
        rangeBad = st_q.count[31] || rangeEnd > 32'(NUM_VP);
        selVp = (gsActive && primVpIdx < 8'(NUM_VP)) ? st_q.vp[primVpIdx] : st_q.vp[0];
        rdVp = (st_q.sel < 8'(NUM_VP)) ? st_q.vp[st_q.sel] : st_q.vp[0];
        rdOx = vpCenter(rdVp.x, rdVp.w);
        rdOy = vpCenter(rdVp.y, rdVp.h);
        accept = primValid && st_q.primReady;
        pass = (!gsActive || primStream == 2'h0)
            && !st_q.ctrl[vtr_pkg::CTRL_DROP]
            && fragX >= 0 && fragY >= 0
            && 16'(fragX) < FB_W && 16'(fragY) < FB_H;
        st_d.opValid = 1'b0;

        // write channel capture
        if (awvalid && st_q.awready) begin
            st_d.awHave = 1'b1;
            st_d.awAddr = awaddr;
            st_d.awready = 1'b0;
        end
        if (wvalid && st_q.wready) begin
            st_d.wHave = 1'b1;
            st_d.wData = wdata;
            st_d.wStrb = wstrb;
            st_d.wready = 1'b0;
        end
        if (bvalid && bready) begin
            st_d.bvalid = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready = 1'b1;
        end
        if (doWrite) begin
            st_d.awHave = 1'b0;
            st_d.wHave = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = vtr_pkg::RESP_OKAY;
            unique case (st_q.awAddr)
                vtr_pkg::OFS_CTRL: begin
                    st_d.ctrl = 4'(applyStrb(32'(st_q.ctrl), st_q.wData, st_q.wStrb));
                end
                vtr_pkg::OFS_FIRST: begin
                    st_d.first = 8'(applyStrb(32'(st_q.first), st_q.wData, st_q.wStrb));
                end
                vtr_pkg::OFS_COUNT: begin
                    st_d.count = applyStrb(st_q.count, st_q.wData, st_q.wStrb);
                end
                vtr_pkg::OFS_X: begin
                    st_d.sx = applyStrb(st_q.sx, st_q.wData, st_q.wStrb);
                end
                vtr_pkg::OFS_Y: begin
                    st_d.sy = applyStrb(st_q.sy, st_q.wData, st_q.wStrb);
                end
                vtr_pkg::OFS_W: begin
                    st_d.sw = applyStrb(st_q.sw, st_q.wData, st_q.wStrb);
                end
                vtr_pkg::OFS_H: begin
                    st_d.sh = applyStrb(st_q.sh, st_q.wData, st_q.wStrb);
                end
                vtr_pkg::OFS_CMD: begin
                    if (st_q.wData[1:0] == vtr_pkg::CMD_RANGE) begin
                        if (rangeBad || clampNeg) begin
                            st_d.errSticky = 1'b1;
                        end else begin
                            for (int i = 0; i < NUM_VP; i++) begin
                                if (32'(i) >= 32'(st_q.first) && 32'(i) < rangeEnd) begin
                                    st_d.vp[i] = clampVp;
                                end
                            end
                        end
                    end else if (st_q.wData[1:0] == vtr_pkg::CMD_ALL) begin
                        if (clampNeg) begin
                            st_d.errSticky = 1'b1;
                        end else begin
                            for (int i = 0; i < NUM_VP; i++) begin
                                st_d.vp[i] = clampVp;
                            end
                        end
                    end
                end
                vtr_pkg::OFS_STATUS: begin
                    if (st_q.wData[0] && st_q.wStrb[0]) begin
                        st_d.errSticky = 1'b0;
                    end
                end
                vtr_pkg::OFS_SEL: begin
                    st_d.sel = 8'(applyStrb(32'(st_q.sel), st_q.wData, st_q.wStrb));
                end
                vtr_pkg::OFS_OP: begin
                    st_d.opValid = !st_q.ctrl[vtr_pkg::CTRL_DROP];
                    st_d.opCode = st_q.wData[2:0];
                end
                vtr_pkg::OFS_BOUNDS, vtr_pkg::OFS_DIMS, vtr_pkg::OFS_RD_CORNER,
                vtr_pkg::OFS_RD_SCALE, vtr_pkg::OFS_RD_CENTER, vtr_pkg::OFS_RD_DEPTH: begin
                end
                default: begin
                    st_d.bresp = vtr_pkg::RESP_SLVERR;
                end
            endcase
        end

        // read channel
        if (rvalid && rready) begin
            st_d.rvalid = 1'b0;
            st_d.arready = 1'b1;
        end
        if (arvalid && st_q.arready) begin
            st_d.arready = 1'b0;
            st_d.rvalid = 1'b1;
            st_d.rresp = vtr_pkg::RESP_OKAY;
            unique case (araddr)
                vtr_pkg::OFS_CTRL: st_d.rdata = 32'(st_q.ctrl);
                vtr_pkg::OFS_FIRST: st_d.rdata = 32'(st_q.first);
                vtr_pkg::OFS_COUNT: st_d.rdata = st_q.count;
                vtr_pkg::OFS_X: st_d.rdata = st_q.sx;
                vtr_pkg::OFS_Y: st_d.rdata = st_q.sy;
                vtr_pkg::OFS_W: st_d.rdata = st_q.sw;
                vtr_pkg::OFS_H: st_d.rdata = st_q.sh;
                vtr_pkg::OFS_CMD: st_d.rdata = 32'h0000_0000;
                vtr_pkg::OFS_STATUS: st_d.rdata = 32'(st_q.errSticky);
                vtr_pkg::OFS_BOUNDS: st_d.rdata = {BOUND_MAX, BOUND_MIN};
                vtr_pkg::OFS_DIMS: st_d.rdata = {MAX_DIM, MAX_DIM};
                vtr_pkg::OFS_SEL: st_d.rdata = 32'(st_q.sel);
                vtr_pkg::OFS_RD_CORNER: st_d.rdata = {rdVp.y, rdVp.x};
                vtr_pkg::OFS_RD_SCALE: st_d.rdata = {rdVp.h, rdVp.w};
                vtr_pkg::OFS_RD_CENTER: begin
                    st_d.rdata = {rdOy[15:0], rdOx[15:0]};
                end
                vtr_pkg::OFS_RD_DEPTH: begin
                    st_d.rdata = {vtr_pkg::DEPTH_FAR_RESET, vtr_pkg::DEPTH_NEAR_RESET};
                end
                vtr_pkg::OFS_OP: st_d.rdata = 32'(st_q.opCode);
                default: begin
                    st_d.rdata = 32'h0000_0000;
                    st_d.rresp = vtr_pkg::RESP_SLVERR;
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////////////
        // primitive stage, sampled whole at acceptance
        if (outValid && outReady) begin
            st_d.outValid = 1'b0;
        end
        if (accept && pass) begin
            st_d.outValid = 1'b1;
            st_d.outCx = {fragX, 1'b1};
            st_d.outCy = {fragY, 1'b1};
            st_d.outOx = vpCenter(selVp.x, selVp.w);
            st_d.outOy = vpCenter(selVp.y, selVp.h);
            st_d.outW = selVp.w;
            st_d.outH = selVp.h;
            st_d.outColor = convColor;
        end
        st_d.primReady = !st_d.outValid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            st_q <= '0;
            st_q.awready <= 1'b1;
            st_q.wready <= 1'b1;
            st_q.arready <= 1'b1;
            st_q.primReady <= 1'b1;
            st_q.ctrl <= vtr_pkg::CTRL_RESET;
            for (int i = 0; i < NUM_VP; i++) begin
                st_q.vp[i].x <= 16'sh0000;
                st_q.vp[i].y <= 16'sh0000;
                st_q.vp[i].w <= INIT_W;
                st_q.vp[i].h <= INIT_H;
            end
        end else begin
            st_q <= st_d;
        end
    end

    assign awready = st_q.awready;
    assign wready = st_q.wready;
    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign arready = st_q.arready;
    assign rvalid = st_q.rvalid;
    assign rresp = st_q.rresp;
    assign rdata = st_q.rdata;
    assign primReady = st_q.primReady;
    assign outValid = st_q.outValid;
    assign outCenterX = st_q.outCx;
    assign outCenterY = st_q.outCy;
    assign outOriginX = st_q.outOx;
    assign outOriginY = st_q.outOy;
    assign outScaleW = st_q.outW;
    assign outScaleH = st_q.outH;
    assign outColor = st_q.outColor;
    assign opValid = st_q.opValid;
    assign opCode = st_q.opCode;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_rangeCmd;
        doCmd && st_q.wData[1:0] == vtr_pkg::CMD_RANGE;
    endsequence
    sequence s_allCmd;
        doCmd && st_q.wData[1:0] == vtr_pkg::CMD_ALL && !clampNeg;
    endsequence

    property p_rangeReject;
        s_rangeCmd and rangeBad |=> st_q.errSticky && $stable(st_q.vp);
    endproperty
    a_rangeReject: assert property (p_rangeReject) else $error("bad range changed state");

    property p_single;
        s_rangeCmd and (st_q.count == 32'd1 && !rangeBad && !clampNeg)
            |=> st_q.vp[$past(st_q.first)] == $past(clampVp);
    endproperty
    a_single: assert property (p_single) else $error("single write not applied");

    property p_broadcast;
        s_allCmd |=> st_q.vp[0] == $past(clampVp) && st_q.vp[NUM_VP-1] == $past(clampVp);
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast missed entry");

    property p_center;
        accept && pass |=> outValid && outOriginX == $past(vpCenter(selVp.x, selVp.w));
    endproperty
    a_center: assert property (p_center) else $error("center wrong");

    property p_dimClamp;
        st_q.vp[0].w <= MAX_DIM && st_q.vp[0].h <= MAX_DIM;
    endproperty
    a_dimClamp: assert property (p_dimClamp) else $error("extent above maximum");

    property p_negative;
        s_rangeCmd and clampNeg |=> st_q.errSticky && $stable(st_q.vp);
    endproperty
    a_negative: assert property (p_negative) else $error("negative extent accepted");

    property p_bounds;
        outValid |-> outCenterX[16:1] < FB_W && outCenterY[16:1] < FB_H;
    endproperty
    a_bounds: assert property (p_bounds) else $error("fragment outside target");

    property p_stream;
        accept && gsActive && primStream != 2'h0 && !outValid |=> !outValid;
    endproperty
    a_stream: assert property (p_stream) else $error("non-zero stream passed");

    property p_drop;
        accept && st_q.ctrl[vtr_pkg::CTRL_DROP] && !outValid |=> !outValid;
    endproperty
    a_drop: assert property (p_drop) else $error("dropped primitive passed");

    property p_opIgnore;
        doWrite && st_q.awAddr == vtr_pkg::OFS_OP && st_q.ctrl[vtr_pkg::CTRL_DROP] |=> !opValid;
    endproperty
    a_opIgnore: assert property (p_opIgnore) else $error("op not ignored");

    property p_centerHalf;
        outValid |-> outCenterX[0] && outCenterY[0];
    endproperty
    a_centerHalf: assert property (p_centerHalf) else $error("center not at half unit");
endmodule

/* File: inc/vtr_pkg.sv */
/*
 viewport transform front end: shared register map, field layout and reset values.
 assumes a 32-bit AXI4-Lite register bus with byte addresses in the low 8 bits.
*/
package vtr_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIRST = 8'h04;
    localparam logic [7:0] OFS_COUNT = 8'h08;
    localparam logic [7:0] OFS_X = 8'h0C;
    localparam logic [7:0] OFS_Y = 8'h10;
    localparam logic [7:0] OFS_W = 8'h14;
    localparam logic [7:0] OFS_H = 8'h18;
    localparam logic [7:0] OFS_CMD = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_BOUNDS = 8'h24;
    localparam logic [7:0] OFS_DIMS = 8'h28;
    localparam logic [7:0] OFS_SEL = 8'h2C;
    localparam logic [7:0] OFS_RD_CORNER = 8'h30;
    localparam logic [7:0] OFS_RD_SCALE = 8'h34;
    localparam logic [7:0] OFS_RD_CENTER = 8'h38;
    localparam logic [7:0] OFS_RD_DEPTH = 8'h3C;
    localparam logic [7:0] OFS_OP = 8'h40;
    localparam int CTRL_DROP = 0;
    localparam int CTRL_CLAMP = 1;
    localparam int CTRL_SIGNED = 2;
    localparam int CTRL_INDEX = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [1:0] CMD_RANGE = 2'h1;
    localparam logic [1:0] CMD_ALL = 2'h2;
    localparam logic [15:0] DEPTH_NEAR_RESET = 16'h0000;
    localparam logic [15:0] DEPTH_FAR_RESET = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic [15:0] w;
        logic [15:0] h;
    } vtr_vp_t;
endpackage

/* File: rtl/vtr_vp_clamp.sv */
/*
 viewport clamp: corner into bounds range, extent to maximum dims, sign check.
 assumes signed 32-bit staged values; purely combinational.
*/
`timescale 1ns/1ps
module vtr_vp_clamp #(
    parameter logic signed [15:0] BOUND_MIN = -16'sd16384,
    parameter logic signed [15:0] BOUND_MAX = 16'sd16383,
    parameter logic [15:0] MAX_DIM = 16'h4000
) (
    // staged values
    input wire logic signed [31:0] inX,
    input wire logic signed [31:0] inY,
    input wire logic signed [31:0] inW,
    input wire logic signed [31:0] inH,
    // clamped entry
    output vtr_pkg::vtr_vp_t vp,
    output logic negative
);
    function automatic logic signed [15:0] clampCorner(input logic signed [31:0] v);
        if (v < 32'(BOUND_MIN)) begin
            return BOUND_MIN;
        end else if (v > 32'(BOUND_MAX)) begin
            return BOUND_MAX;
        end
        return v[15:0];
    endfunction

    function automatic logic [15:0] clampDim(input logic signed [31:0] v);
        if (v < 0) begin
            return 16'h0000;
        end else if (v > 32'(MAX_DIM)) begin
            return MAX_DIM;
        end
        return v[15:0];
    endfunction

    always_comb begin
        vp.x = clampCorner(inX);
        vp.y = clampCorner(inY);
        vp.w = clampDim(inW);
        vp.h = clampDim(inH);
        negative = inW[31] | inH[31];
    end
endmodule

/* File: rtl/vtr_color_conv.sv */
/*
 final colour conversion: float pass, normalized fixed point, index rounding.
 assumes integer components sit in the low IN_BITS of the word.
*/
`timescale 1ns/1ps
module vtr_color_conv #(
    parameter int IN_BITS = 16,
    parameter int OUT_BITS = 8,
    parameter int IDX_FRAC = 4,
    parameter int IDX_BITS = 8
) (
    // colour and mode
    input wire logic [31:0] colorIn,
    input wire logic clampEn,
    input wire logic signedFmt,
    input wire logic indexMode,
    // converted colour
    output logic [31:0] colorOut
);
    logic [OUT_BITS-1:0] fixedVal;
    logic [31:0] rounded;

    generate
        if (OUT_BITS < IN_BITS) begin : g_narrow
            assign fixedVal = colorIn[IN_BITS-1 -: OUT_BITS];
        end else begin : g_wide
            assign fixedVal = {colorIn[IN_BITS-1:0], {(OUT_BITS-IN_BITS){1'b0}}};
        end
    endgenerate

    assign rounded = (colorIn + 32'(1 << (IDX_FRAC - 1))) >> IDX_FRAC;

    always_comb begin
        if (indexMode) begin
            colorOut = {{(32-IDX_BITS){1'b0}}, rounded[IDX_BITS-1:0]};
        end else if (!clampEn) begin
            colorOut = colorIn;
        end else if (signedFmt) begin
            colorOut = {{(32-OUT_BITS){fixedVal[OUT_BITS-1]}}, fixedVal};
        end else begin
            colorOut = {{(32-OUT_BITS){1'b0}}, fixedVal};
        end
    end
endmodule

/* File: sim/vtr_rast_sink.sv */
/* rasterizer stand-in: takes fragments with random stalls and counts them.
 assumes the front end's outValid/outReady handshake on one clock. */
`timescale 1ns/1ps
module vtr_rast_sink (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // fragments
    input wire logic outValid,
    output logic outReady,
    output int got
);
    logic [31:0] s = 32'h000160C6;
    always @(posedge clock) begin
        s <= s ^ (s << 13) ^ (s >> 17);
        outReady <= s[0] | s[1];
        if (reset)
            got <= 0;
        else if (outValid && outReady)
            got <= got + 1;
    end
endmodule

/* File: sim/test_vtr_front.sv */
/* self-checking bench of the viewport front end against an integer model.
 assumes vtr_front defaults and the rasterizer stand-in. */
`timescale 1ns/1ps
module test_vtr_front;
    logic clock = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, primVpIdx = 0;
    logic [31:0] wdata = 0, primColor = 0, rdVal, seed = 32'h000160C6, rdata, outColor;
    logic primValid = 0, gsActive = 0, awready, wready, bvalid, arready, rvalid;
    logic primReady, outValid, outReady, opValid;
    logic [1:0] primStream = 0, bresp, rresp;
    logic signed [15:0] fragX = 0, fragY = 0;
    logic [16:0] outCenterX, outCenterY, outOriginX, outOriginY;
    logic [15:0] outScaleW, outScaleH;
    logic [2:0] opCode;
    int fail_count = 0, compares = 0, ops = 0, got, fx, mx[16], my[16], mw[16], mh[16];
    always #2 clock = ~clock;
    always @(posedge clock) if (opValid === 1'b1) ops++;
    vtr_front i_vtr_front (.clock, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .primValid, .primReady, .gsActive, .primStream, .primVpIdx, .fragX,
        .fragY, .primColor, .outValid, .outReady, .outCenterX, .outCenterY, .outOriginX,
        .outOriginY, .outScaleW, .outScaleH, .outColor, .opValid, .opCode);
    vtr_rast_sink i_vtr_rast_sink (.clock, .reset, .outValid, .outReady, .got);
    ////////////////////////////////////////////////////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task results;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task tmo(input int n);
        if (n >= 200) begin
            fail_count++;
            results();
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            n++;
        end while (bvalid !== 1'b1 && n < 200);
        tmo(n);
    endtask
    task rd(input logic [7:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 0;
            n++;
        end while (rvalid !== 1'b1 && n < 200);
        rdVal = rdata;
        tmo(n);
    endtask
    task mset(input int f, input int c, input int x, input int y, input int w, input int h);
        for (int i = f; i < f + c; i++) begin
            mx[i] = x < -16384 ? -16384 : (x > 16383 ? 16383 : x);
            my[i] = y < -16384 ? -16384 : (y > 16383 ? 16383 : y);
            mw[i] = w > 8192 ? 8192 : w;
            mh[i] = h > 8192 ? 8192 : h;
        end
    endtask
    task stage(input int x, input int y, input int w, input int h);
        wr(vtr_pkg::OFS_X, x);
        wr(vtr_pkg::OFS_Y, y);
        wr(vtr_pkg::OFS_W, w);
        wr(vtr_pkg::OFS_H, h);
    endtask
    task vchk(input int i);
        int ox, oy;
        ox = 2 * mx[i] + mw[i];
        oy = 2 * my[i] + mh[i];
        wr(vtr_pkg::OFS_SEL, i);
        rd(vtr_pkg::OFS_RD_CORNER);
        chk("corner", rdVal, {my[i][15:0], mx[i][15:0]});
        rd(vtr_pkg::OFS_RD_SCALE);
        chk("scale", rdVal, {mh[i][15:0], mw[i][15:0]});
        rd(vtr_pkg::OFS_RD_CENTER);
        chk("center", rdVal, {oy[15:0], ox[15:0]});
    endtask
    task prim(input logic [1:0] st, input logic gs, input int x, input logic [31:0] ec, bit ok);
        int n;
        n = 0;
        primStream <= st;
        gsActive <= gs;
        fragX <= 16'(x);
        fragY <= 16'(x / 2);
        primValid <= 1;
        @(posedge clock);
        primValid <= 0;
        do begin
            @(posedge clock);
            n++;
        end while (outValid !== 1'b1 && n < (ok ? 200 : 4));
        chk("emitted", outValid, ok);
        if (ok) begin
            chk("centerX", outCenterX, 2 * x + 1);
            chk("centerY", outCenterY, 2 * (x / 2) + 1);
            chk("originX", outOriginX, 17'(2 * mx[0] + mw[0]));
            chk("scaleH", outScaleH, mh[0]);
            chk("colour", outColor, ec);
            while (!(outValid === 1'b1 && outReady === 1'b1) && n < 200) begin
                @(posedge clock);
                n++;
            end
            tmo(n);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        reset <= 0;
        mset(0, 16, 0, 0, 640, 480);
        rd(vtr_pkg::OFS_CTRL);
        chk("ctrl", rdVal, 0);
        vchk(0);
        vchk(15);
        rd(vtr_pkg::OFS_RD_DEPTH);
        chk("depth", rdVal, 32'hFFFF0000);
        rd(vtr_pkg::OFS_BOUNDS);
        chk("bounds", rdVal, 32'h3FFFC000);
        rd(vtr_pkg::OFS_DIMS);
        chk("dims", rdVal, 32'h20002000);
        rd(8'h80);
        chk("rresp", rresp, vtr_pkg::RESP_SLVERR);
        $display("reset and map test done");
        stage(-20000, 7, 20000, 33);
        wr(vtr_pkg::OFS_FIRST, 14);
        wr(vtr_pkg::OFS_COUNT, 2);
        wr(vtr_pkg::OFS_CMD, vtr_pkg::CMD_RANGE);
        mset(14, 2, -20000, 7, 20000, 33);
        vchk(13);
        vchk(15);
        wr(vtr_pkg::OFS_FIRST, 15);
        wr(vtr_pkg::OFS_CMD, vtr_pkg::CMD_RANGE);
        rd(vtr_pkg::OFS_STATUS);
        chk("overrun", rdVal[0], 1);
        wr(vtr_pkg::OFS_STATUS, 1);
        stage(3, 4, -1, 9);
        wr(vtr_pkg::OFS_FIRST, 3);
        wr(vtr_pkg::OFS_COUNT, 1);
        wr(vtr_pkg::OFS_CMD, vtr_pkg::CMD_RANGE);
        rd(vtr_pkg::OFS_STATUS);
        chk("negative", rdVal[0], 1);
        vchk(15);
        wr(vtr_pkg::OFS_STATUS, 1);
        wr(vtr_pkg::OFS_W, 12);
        wr(vtr_pkg::OFS_CMD, vtr_pkg::CMD_RANGE);
        mset(3, 1, 3, 4, 12, 9);
        vchk(3);
        vchk(4);
        stage(5, 9, 100, 50);
        wr(vtr_pkg::OFS_CMD, vtr_pkg::CMD_ALL);
        mset(0, 16, 5, 9, 100, 50);
        vchk(0);
        vchk(15);
        $display("viewport test done");
        for (int k = 0; k < 6; k++) begin
            fx = int'(rnd() % 640);
            primColor <= rnd();
            @(posedge clock);
            prim(0, k[0], fx, primColor, 1);
        end
        prim(1, 1, 10, primColor, 0);
        prim(1, 0, 11, primColor, 1);
        prim(0, 0, 640, primColor, 0);
        prim(0, 0, -1, primColor, 0);
        wr(vtr_pkg::OFS_CTRL, 2);
        primColor <= 32'h1234ABCD;
        prim(0, 0, 2, 32'h000000AB, 1);
        wr(vtr_pkg::OFS_CTRL, 6);
        prim(0, 0, 3, 32'hFFFFFFAB, 1);
        wr(vtr_pkg::OFS_CTRL, 8);
        prim(0, 0, 4, 32'h000000BD, 1);
        wr(vtr_pkg::OFS_OP, 3);
        wr(vtr_pkg::OFS_CTRL, 1);
        prim(0, 0, 5, primColor, 0);
        wr(vtr_pkg::OFS_OP, 4);
        @(posedge clock);
        chk("ops", ops, 1);
        chk("fragments", got, 10);
        $display("primitive test done");
        results();
    end
endmodule
